// ---- adc_input_port.sv ----
// converter input port: sampling, gain scaling, strobe qualification,
// complex pairing and first decimator sequencing, with an AHB-Lite slave
// assumes one clock MCLK, inputs synchronous to it, a single bus slave
//
// What this block does
// - flip clear: shift right by code plus bias
// - flip set: shift right by seven minus code plus bias
// - flip set, bias zero: code five shifts two
// - flip set, bias six: code five unshifted
// - single real: strobe high enables capture
// - diversity: strobe high channel A, low B
// - two-phase: only first sample after transition
// - complex: high in-phase, low quadrature, paired
// - in-phase cycle: load, only first integrator
// - quadrature cycle: complete sums, later stages run
// - inputs sampled on rising processing clock edge
// - mantissa two's complement, code unsigned
// - bias bits seven to five, flip bit four
// - input mode from mode control register
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module adc_input_port
   import input_port_pkg::*;
(
   input  wire logic                MCLK,
   input  wire logic                RST,
   input  wire logic                HSEL,
   input  wire logic [31:0]         HADDR,
   input  wire logic [1:0]          HTRANS,
   input  wire logic                HWRITE,
   input  wire logic [2:0]          HSIZE,
   input  wire logic [31:0]         HWDATA,
   input  wire logic                HREADY,
   output logic      [31:0]         HRDATA,
   output logic                     HREADYOUT,
   output logic                     HRESP,
   input  wire logic [MANT_W-1:0]   MANTISSA,
   input  wire logic [EXP_W-1:0]    GAIN_RANGE_CODE,
   input  wire logic                CHAN_SEL,
   output logic      [WORD_W-1:0]   SAMPLE_WORD,
   output logic                     SAMPLE_VALID,
   output logic                     SAMPLE_CHAN_B,
   output logic                     SAMPLE_PHASE_Q,
   output logic      [WORD_W-1:0]   PAIRED_I_WORD,
   output logic                     FIRST_INTEG_EN,
   output logic                     LATER_STAGES_EN,
   output logic                     MIX_SWAP,
   output logic                     I_PATH_SUBTRACT,
   output logic                     RATIO_ERROR
);

   // ******************************
   // state
   // ******************************
   typedef struct packed {
      logic [MANT_W-1:0] in_mant;
      logic [EXP_W-1:0]  in_exp;
      logic              in_ab;
      logic              ph_act;
      logic              ph_write;
      logic [IDX_W-1:0]  ph_idx;
      logic [31:0]       rdata;
      input_mode_e       mode;
      logic [EXP_W-1:0]  bias;
      logic              flip;
      logic [3:0]        ratio;
      logic              soft_clr;
      logic [15:0]       count;
      logic [WORD_W-1:0] out_word;
      logic [WORD_W-1:0] pair_word;
      logic              pair_ok;
      logic              out_valid;
      logic              out_chan_b;
      logic              out_phase_q;
      logic              integ1_en;
      logic              later_en;
      logic              mix_swap;
      logic              i_sub;
   } core_s;

   core_s            st_reg;
   core_s            st_next;
   sample_if         sif ();
   logic             addr_take;
   logic             ratio_bad;
   logic             is_cplx;

   // ******************************
   // parts
   // ******************************
   gain_scaler u_scaler
   (
      .clk (MCLK),
      .rst (RST),
      .sif (sif.scale)
   );

   strobe_qualifier u_qual
   (
      .clk (MCLK),
      .rst (RST),
      .sif (sif.qual)
   );

   // ******************************
   // staged inputs and settings toward the parts
   // ******************************
   // mantissa is carried as a signed word, code as an unsigned count
   assign sif.mant     = st_reg.in_mant;
   assign sif.exponent = st_reg.in_exp;
   assign sif.strobe   = st_reg.in_ab;
   assign sif.bias     = st_reg.bias;
   assign sif.flip     = st_reg.flip;
   assign sif.mode     = st_reg.mode;
   assign sif.soft_clr = st_reg.soft_clr;

   assign addr_take = HSEL & HTRANS[1] & HREADY;
   assign is_cplx   = st_reg.mode == MODE_COMPLEX;
   // complex pairing only lines up when the first decimator halves
   assign ratio_bad = is_cplx & (st_reg.ratio != RATIO_CPLX);

   // ******************************
   // next state
   // ******************************
   always_comb
   begin
      st_next = st_reg;

      // inputs latched on every rising edge
      st_next.in_mant = MANTISSA;
      st_next.in_exp  = GAIN_RANGE_CODE;
      st_next.in_ab   = CHAN_SEL;

      // soft clear lasts one cycle
      st_next.soft_clr = 1'b0;

      // bus data phase: a write lands at the end of it
      if (st_reg.ph_act & st_reg.ph_write)
      begin
         case (st_reg.ph_idx)
            IDX_MODE:
            begin
               if (HWDATA[MODE_LSB+1:MODE_LSB] != 2'b11)
                  st_next.mode =
                     input_mode_e'(HWDATA[MODE_LSB+1:MODE_LSB]);
            end
            IDX_SCALE:
            begin
               st_next.bias = HWDATA[BIAS_LSB+EXP_W-1:BIAS_LSB];
               st_next.flip = HWDATA[FLIP_BIT];
            end
            IDX_CTRL:
            begin
               st_next.soft_clr = HWDATA[SOFT_BIT];
               st_next.ratio    = HWDATA[RATIO_LSB+3:RATIO_LSB];
            end
            default:
            begin
               st_next.soft_clr = 1'b0;
            end
         endcase
      end

      // bus address phase: read data is prepared for the data phase
      st_next.ph_act   = addr_take;
      st_next.ph_write = HWRITE;
      st_next.ph_idx   = HADDR[IDX_W+1:2];
      st_next.rdata    = '0;
      if (addr_take & ~HWRITE)
      begin
         case (HADDR[IDX_W+1:2])
            IDX_MODE:
               st_next.rdata[MODE_LSB+1:MODE_LSB] = st_reg.mode;
            IDX_SCALE:
            begin
               st_next.rdata[BIAS_LSB+EXP_W-1:BIAS_LSB] = st_reg.bias;
               st_next.rdata[FLIP_BIT] = st_reg.flip;
            end
            IDX_CTRL:
               st_next.rdata[RATIO_LSB+3:RATIO_LSB] = st_reg.ratio;
            IDX_STAT:
            begin
               st_next.rdata[15:0]       = st_reg.count;
               st_next.rdata[RERR_BIT]   = ratio_bad;
               st_next.rdata[STROBE_BIT] = st_reg.in_ab;
            end
            default:
               st_next.rdata = '0;
         endcase
      end

      // qualified sample stage
      st_next.out_word    = sif.word;
      st_next.out_valid   = sif.valid;
      st_next.out_chan_b  = sif.chan_b;
      st_next.out_phase_q = sif.phase_q;
      st_next.integ1_en   = 1'b0;
      st_next.later_en    = 1'b0;
      st_next.mix_swap    = 1'b0;
      st_next.i_sub       = 1'b0;

      if (sif.valid)
      begin
         st_next.count = st_reg.count + 16'h0001;
         if (is_cplx)
         begin
            if (!sif.phase_q)
            begin
               // in-phase word: cos to I, sin to Q, first integrator only
               st_next.pair_word = sif.word;
               st_next.pair_ok   = 1'b1;
               st_next.integ1_en = 1'b1;
            end
            else
            begin
               // quadrature word closes the complex product
               st_next.integ1_en = 1'b1;
               st_next.mix_swap  = 1'b1;
               st_next.i_sub     = 1'b1;
               st_next.later_en  = st_reg.pair_ok;
               st_next.pair_ok   = 1'b0;
            end
         end
         else
         begin
            st_next.integ1_en = 1'b1;
            st_next.later_en  = 1'b1;
         end
      end

      // leaving complex mode drops a half-built pair
      if (!is_cplx)
         st_next.pair_ok = 1'b0;

      if (st_reg.soft_clr)
      begin
         st_next.pair_ok = 1'b0;
         st_next.count   = COUNT_RST;
      end
   end

   // ******************************
   // registers
   // ******************************
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         st_reg       <= '0;
         st_reg.mode  <= MODE_SINGLE_REAL;
         st_reg.bias  <= BIAS_RST;
         st_reg.ratio <= RATIO_RST;
         st_reg.count <= COUNT_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign HRDATA          = st_reg.rdata;
   assign HREADYOUT       = 1'b1;
   assign HRESP           = 1'b0;
   assign SAMPLE_WORD     = st_reg.out_word;
   assign SAMPLE_VALID    = st_reg.out_valid;
   assign SAMPLE_CHAN_B   = st_reg.out_chan_b;
   assign SAMPLE_PHASE_Q  = st_reg.out_phase_q;
   assign PAIRED_I_WORD   = st_reg.pair_word;
   assign FIRST_INTEG_EN  = st_reg.integ1_en;
   assign LATER_STAGES_EN = st_reg.later_en;
   assign MIX_SWAP        = st_reg.mix_swap;
   assign I_PATH_SUBTRACT = st_reg.i_sub;
   assign RATIO_ERROR     = ratio_bad;

endmodule : adc_input_port

// ---- adc_input_port_exponent_scaler_tb.sv ----
// self-checking bench for the converter input port
// assumes the source model and the checker are compiled before it
`timescale 1ns/100ps
module adc_input_port_exponent_scaler_tb
   import input_port_pkg::*;
();
   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic              tag;
   } expect_s;
   logic              MCLK = 1'b0;
   logic              RST = 1'b1;
   logic              HSEL = 1'b0;
   logic [31:0]       HADDR = 32'h0000_0000;
   logic [1:0]        HTRANS = 2'h0;
   logic              HWRITE = 1'b0;
   logic [31:0]       HWDATA = 32'h0000_0000;
   logic [31:0]       HRDATA;
   logic              HREADYOUT;
   logic              HRESP;
   logic [MANT_W-1:0] MANTISSA;
   logic [EXP_W-1:0]  GAIN_RANGE_CODE;
   logic              CHAN_SEL;
   logic [WORD_W-1:0] SAMPLE_WORD;
   logic              SAMPLE_VALID;
   logic              SAMPLE_CHAN_B;
   logic              SAMPLE_PHASE_Q;
   logic              RATIO_ERROR;
   logic              run = 1'b0;
   logic              two_phase = 1'b0;
   logic              fixed_pt = 1'b0;
   logic [1:0]        rate = 2'h0;
   logic [1:0]        mode = 2'h0;
   logic              flip = 1'b0;
   logic [2:0]        bias = 3'h0;
   logic              prev = 1'b0;
   logic [31:0]       r;
   expect_s           e;
   expect_s           q[$];
   int                errors = 0;
   int                compares = 0;
   int                pushes = 0;
   logic [9:0]        idx_tab[4] = '{IDX_MODE, IDX_SCALE, IDX_CTRL, 10'h3FF};
   logic [31:0]       rst_tab[4] = '{32'h0, 32'h0, 32'h0000_0020, 32'h0};
   logic              f_tab[3] = '{1'b0, 1'b1, 1'b1};
   logic [2:0]        b_tab[3] = '{3'h3, 3'h0, 3'h6};

   always #25 MCLK = ~MCLK;

   adc_input_port u_adc_input_port (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MANTISSA(MANTISSA),
      .GAIN_RANGE_CODE(GAIN_RANGE_CODE), .CHAN_SEL(CHAN_SEL),
      .SAMPLE_WORD(SAMPLE_WORD), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE_CHAN_B(SAMPLE_CHAN_B), .SAMPLE_PHASE_Q(SAMPLE_PHASE_Q),
      .PAIRED_I_WORD(), .FIRST_INTEG_EN(), .LATER_STAGES_EN(),
      .MIX_SWAP(), .I_PATH_SUBTRACT(), .RATIO_ERROR(RATIO_ERROR));

   adc_source_model u_adc_source_model (.clk(MCLK), .run(run),
      .two_phase(two_phase), .fixed_pt(fixed_pt), .rate(rate),
      .mant(MANTISSA), .code(GAIN_RANGE_CODE), .strobe(CHAN_SEL));

   // ****************
   // expectations and comparison
   // ****************
   function automatic logic [WORD_W-1:0] scaled(logic [MANT_W-1:0] m,
                                                logic [EXP_W-1:0]  c);
      logic [EXP_W-1:0] s;
      s = flip ? EXP_TOP - c + bias : c + bias;
      return $signed({m, 7'h00}) >>> s;
   endfunction : scaled

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   always @(posedge MCLK)
   begin
      if (RST)
         prev = 1'b0;
      else
      begin
         if (mode == 2'h0 ? CHAN_SEL : CHAN_SEL != prev)
         begin
            q.push_back({scaled(MANTISSA, GAIN_RANGE_CODE),
                         mode != 2'h0 && !CHAN_SEL});
            pushes++;
         end
         prev = CHAN_SEL;
         if (SAMPLE_VALID !== 1'b0)
         begin
            e = q.size() > 0 ? q.pop_front() : 'x;
            check("word", {9'h0, SAMPLE_WORD}, {9'h0, e.word});
            check("tag", mode == 2'h1 ? SAMPLE_CHAN_B : SAMPLE_PHASE_Q,
                  e.tag);
         end
      end
   end

   // ****************
   // bus and source tasks
   // ****************
   task automatic bus(logic w, logic [9:0] idx, logic [31:0] wd);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= {20'h0_0000, idx, 2'h0};
      HWRITE <= w;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
      check("response", {31'h0, HRESP}, 32'h0);
   endtask : bus

   task automatic setup(logic [1:0] m, logic f, logic [2:0] b);
      bus(1'b1, IDX_MODE, {30'h0, m});
      bus(1'b1, IDX_SCALE, {24'h0, b, f, 4'h0});
      mode = m;
      flip = f;
      bias = b;
   endtask : setup

   task automatic burst(logic [1:0] rt, int n);
      two_phase <= mode != 2'h0;
      rate      <= rt;
      run       <= 1'b1;
      repeat (n) @(posedge MCLK);
      run <= 1'b0;
      repeat (12) @(posedge MCLK);
      check("pending", q.size(), 0);
   endtask : burst

   task automatic final_report;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // ****************
   // main sequence
   // ****************
   initial
   begin
      void'($urandom(27923));
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      foreach (idx_tab[i])
      begin
         bus(1'b0, idx_tab[i], 32'h0);
         check("reset value", r, rst_tab[i]);
      end
      bus(1'b1, IDX_MODE, 32'h0000_0003);
      bus(1'b0, IDX_MODE, 32'h0);
      check("mode refused", r, 32'h0);
      fixed_pt <= 1'b1;
      setup(2'h0, 1'b0, 3'h0);
      burst(2'h0, 30);
      fixed_pt <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         setup(2'(i % 3), i < 9 ? f_tab[i / 3] : 1'($urandom),
               i < 9 ? b_tab[i / 3] : 3'($urandom));
         burst(i % 4 == 2 ? 2'h0 : 2'($urandom_range(3)), 40);
      end
      bus(1'b1, IDX_CTRL, 32'h0000_0030);
      @(posedge MCLK);
      check("ratio error", RATIO_ERROR, 1'b1);
      bus(1'b1, IDX_CTRL, 32'h0000_0020);
      @(posedge MCLK);
      check("ratio error", RATIO_ERROR, 1'b0);
      // accepted sample count, then the soft clear that empties it
      bus(1'b0, IDX_STAT, 32'h0);
      check("sample count", r, {16'h0, pushes[15:0]});
      bus(1'b1, IDX_CTRL, 32'h0000_0021);
      @(posedge MCLK);
      bus(1'b0, IDX_STAT, 32'h0);
      check("cleared count", r, 32'h0);
      bus(1'b0, IDX_CTRL, 32'h0);
      check("clear reads zero", r, 32'h0000_0020);
      final_report();
   end

   initial
   begin
      repeat (20000) @(posedge MCLK);
      errors++;
      final_report();
   end
endmodule : adc_input_port_exponent_scaler_tb

bind adc_input_port adc_input_port_properties u_props (.*);

// ---- adc_input_port_properties.sv ----
// bound checker for the converter input port
// assumes single word bus writes and the top module's port names
`timescale 1ns/100ps
module adc_input_port_properties
   import input_port_pkg::*;
(
   input wire logic              MCLK,
   input wire logic              RST,
   input wire logic              HSEL,
   input wire logic [31:0]       HADDR,
   input wire logic [1:0]        HTRANS,
   input wire logic              HWRITE,
   input wire logic              HREADY,
   input wire logic [31:0]       HWDATA,
   input wire logic [MANT_W-1:0] MANTISSA,
   input wire logic [EXP_W-1:0]  GAIN_RANGE_CODE,
   input wire logic              CHAN_SEL,
   input wire logic [WORD_W-1:0] SAMPLE_WORD,
   input wire logic              SAMPLE_VALID,
   input wire logic              SAMPLE_CHAN_B,
   input wire logic              SAMPLE_PHASE_Q,
   input wire logic [WORD_W-1:0] PAIRED_I_WORD,
   input wire logic              FIRST_INTEG_EN,
   input wire logic              LATER_STAGES_EN,
   input wire logic              MIX_SWAP,
   input wire logic              I_PATH_SUBTRACT
);
   // ****************
   // snooped configuration
   // ****************
   logic       wr_reg;
   logic [9:0] idx_reg;
   logic [1:0] mode_reg;
   logic [3:0] scale_reg;
   logic [3:0] age_reg;
   // checks wait until the pipeline holds only post-write samples
   wire        ok = age_reg == 4'h8;
   wire        cx = mode_reg == 2'h2;

   default clocking dc @(posedge MCLK); endclocking
   default disable iff (RST);

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         wr_reg    <= 1'b0;
         mode_reg  <= 2'h0;
         scale_reg <= 4'h0;
         age_reg   <= 4'h0;
      end
      else
      begin
         wr_reg  <= HSEL & HTRANS[1] & HREADY & HWRITE;
         idx_reg <= HADDR[11:2];
         age_reg <= wr_reg ? 4'h0 : age_reg + 4'(age_reg != 4'h8);
         if (wr_reg && idx_reg == IDX_MODE && HWDATA[1:0] != 2'h3)
            mode_reg <= HWDATA[1:0];
         if (wr_reg && idx_reg == IDX_SCALE)
            scale_reg <= HWDATA[7:4];
      end
   end

   function automatic logic [WORD_W-1:0] scaled(logic [MANT_W-1:0] m,
                                                logic [EXP_W-1:0]  c);
      logic [EXP_W-1:0] s;
      s = scale_reg[0] ? 3'h7 - c + scale_reg[3:1] : c + scale_reg[3:1];
      return $signed({m, 7'h00}) >>> s;
   endfunction : scaled

   AST_SINGLE_GATE: assert property (
      ok && mode_reg == 2'h0 |-> SAMPLE_VALID == $past(CHAN_SEL, 3))
      else $error("single mode valid not gated by strobe");
   AST_EDGE_ONLY: assert property (
      ok && mode_reg != 2'h0 |->
      SAMPLE_VALID == ($past(CHAN_SEL, 3) != $past(CHAN_SEL, 4)))
      else $error("two phase valid not tied to strobe change");
   AST_CHAN_TAG: assert property (
      ok && mode_reg == 2'h1 && SAMPLE_VALID |->
      SAMPLE_CHAN_B == !$past(CHAN_SEL, 3))
      else $error("channel tag wrong");
   AST_PHASE_TAG: assert property (
      ok && cx && SAMPLE_VALID |-> SAMPLE_PHASE_Q == !$past(CHAN_SEL, 3))
      else $error("phase tag wrong");
   AST_SCALE: assert property (
      ok && SAMPLE_VALID |-> SAMPLE_WORD ==
      scaled($past(MANTISSA, 3), $past(GAIN_RANGE_CODE, 3)))
      else $error("scaled word wrong");
   AST_INTEG_NEXT: assert property (
      ok |-> FIRST_INTEG_EN == SAMPLE_VALID)
      else $error("first integrator enable not with sample valid");
   AST_REAL_LATER: assert property (
      ok && !cx |-> LATER_STAGES_EN == FIRST_INTEG_EN)
      else $error("real mode later stages not with first integrator");
   AST_I_CYCLE: assert property (
      ok && cx && SAMPLE_VALID && !SAMPLE_PHASE_Q |-> FIRST_INTEG_EN &&
      !LATER_STAGES_EN && !MIX_SWAP && PAIRED_I_WORD == SAMPLE_WORD)
      else $error("in-phase cycle wrong");
   AST_Q_CYCLE: assert property (
      ok && cx && SAMPLE_VALID && !SAMPLE_PHASE_Q ##1
      SAMPLE_VALID && SAMPLE_PHASE_Q |->
      LATER_STAGES_EN && MIX_SWAP && I_PATH_SUBTRACT)
      else $error("quadrature cycle wrong");

   cover property (SAMPLE_VALID && SAMPLE_CHAN_B);
   cover property (LATER_STAGES_EN && MIX_SWAP);
   cover property (ok && SAMPLE_VALID && scale_reg == 4'hD);
endmodule : adc_input_port_properties

// ---- adc_source_model.sv ----
// converter source: mantissa, gain code and channel strobe
// assumes the processing clock and a rate of one sample per rate+1 clocks
`timescale 1ns/100ps
module adc_source_model
   import input_port_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              run,
   input  wire logic              two_phase,
   input  wire logic              fixed_pt,
   input  wire logic [1:0]        rate,
   output logic      [MANT_W-1:0] mant,
   output logic      [EXP_W-1:0]  code,
   output logic                   strobe
);
   logic [1:0] cnt = 2'h0;

   initial
   begin
      mant   = 16'h0000;
      code   = 3'h0;
      strobe = 1'b0;
   end

   always @(posedge clk)
   begin
      cnt <= (cnt == rate || !run) ? 2'h0 : cnt + 2'h1;
      if (run && cnt == 2'h0)
      begin
         mant   <= 16'($urandom);
         code   <= fixed_pt ? 3'h0 : 3'($urandom);
         strobe <= two_phase ? !strobe : 1'b1;
      end
      else
      begin
         // data past its hold time is not left looking valid
         mant   <= ~mant;
         code   <= fixed_pt ? 3'h0 : ~code;
         strobe <= two_phase & run & strobe;
      end
   end
endmodule : adc_source_model

// ---- gain_scaler.sv ----
// arithmetic downshift of the mantissa by the biased gain code
// assumes staged mantissa and code, one cycle to a registered word
`timescale 1ns/100ps
module gain_scaler
   import input_port_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   sample_if.scale   sif
);
   typedef struct packed {
      logic [WORD_W-1:0] word;
   } scale_s;

   scale_s           st_reg;
   scale_s           st_next;
   logic [EXP_W-1:0] shamt;

   always_comb
   begin
      st_next = st_reg;
      // three-bit sums wrap, which is the modulo-8 of the shift count
      if (sif.flip)
         shamt = EXP_TOP - sif.exponent + sif.bias;
      else
         shamt = sif.exponent + sif.bias;
      // sign kept, shifted-out bits kept as fraction below the mantissa
      st_next.word = $signed({sif.mant, {FRAC_W{1'b0}}}) >>> shamt;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sif.word = st_reg.word;
endmodule : gain_scaler

// ---- input_port_pkg.sv ----
// constants and types shared by the converter input port modules
// assumes a single processing clock and word-wide register access
package input_port_pkg;

   // ******************************
   // sample path widths
   // ******************************
   localparam int MANT_W = 16;
   localparam int EXP_W  = 3;
   localparam int FRAC_W = 7;
   localparam int WORD_W = MANT_W + FRAC_W;

   // ******************************
   // register indices, byte address is four times the index
   // ******************************
   localparam int          IDX_W     = 10;
   localparam logic [9:0]  IDX_MODE  = 10'h300;
   localparam logic [9:0]  IDX_CTRL  = 10'h301;
   localparam logic [9:0]  IDX_STAT  = 10'h302;
   localparam logic [9:0]  IDX_SCALE = 10'h305;

   // ******************************
   // field positions
   // ******************************
   localparam int MODE_LSB   = 0;
   localparam int SOFT_BIT   = 0;
   localparam int RATIO_LSB  = 4;
   localparam int FLIP_BIT   = 4;
   localparam int BIAS_LSB   = 5;
   localparam int RERR_BIT   = 16;
   localparam int STROBE_BIT = 17;

   // ******************************
   // values after reset and fixed figures
   // ******************************
   localparam logic [3:0]       RATIO_RST    = 4'h2;
   localparam logic [3:0]       RATIO_CPLX   = 4'h2;
   localparam logic [EXP_W-1:0] BIAS_RST     = 3'h0;
   localparam logic [EXP_W-1:0] EXP_TOP      = 3'h7;
   localparam logic [15:0]      COUNT_RST    = 16'h0000;

   typedef enum logic [1:0] {
      MODE_SINGLE_REAL,
      MODE_DIVERSITY,
      MODE_COMPLEX
   } input_mode_e;

endpackage : input_port_pkg

// ---- sample_if.sv ----
// signals between the input port core, the scaler and the qualifier
// assumes all three parts run on the same clock
`timescale 1ns/100ps
interface sample_if;
   import input_port_pkg::*;
   logic [MANT_W-1:0] mant;
   logic [EXP_W-1:0]  exponent;
   logic              strobe;
   logic [EXP_W-1:0]  bias;
   logic              flip;
   input_mode_e       mode;
   logic              soft_clr;
   logic [WORD_W-1:0] word;
   logic              valid;
   logic              chan_b;
   logic              phase_q;
   modport core  (output mant, exponent, strobe, bias, flip, mode, soft_clr,
                  input word, valid, chan_b, phase_q);
   modport scale (input mant, exponent, bias, flip, output word);
   modport qual  (input strobe, mode, soft_clr,
                  output valid, chan_b, phase_q);
endinterface : sample_if

// ---- strobe_qualifier.sv ----
// turns the channel select strobe into qualified sample events
// assumes the strobe was registered once on the processing clock
`timescale 1ns/100ps
module strobe_qualifier
   import input_port_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   sample_if.qual    sif
);
   typedef struct packed {
      logic prev;
      logic valid;
      logic chan_b;
      logic phase_q;
   } qual_s;

   qual_s st_reg;
   qual_s st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.prev = sif.strobe;
      if (sif.mode == MODE_SINGLE_REAL)
      begin
         st_next.valid   = sif.strobe;
         st_next.chan_b  = 1'b0;
         st_next.phase_q = 1'b0;
      end
      else
      begin
         // a level held over several edges is no new sample
         st_next.valid   = sif.strobe != st_reg.prev;
         st_next.chan_b  = (sif.mode == MODE_DIVERSITY) & ~sif.strobe;
         st_next.phase_q = (sif.mode == MODE_COMPLEX) & ~sif.strobe;
      end
      if (sif.soft_clr)
         st_next = '0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sif.valid   = st_reg.valid;
   assign sif.chan_b  = st_reg.chan_b;
   assign sif.phase_q = st_reg.phase_q;
endmodule : strobe_qualifier
